// file: hdl/emox_regs.vh
`ifndef EMOX_REGS_VH
`define EMOX_REGS_VH

// ==========================================================
// register port offsets
`define EMOX_REG_ACC 2'h0
`define EMOX_REG_FLAGS 2'h1
`define EMOX_REG_EXEC 2'h2

// ==========================================================
// flag register bit positions
`define EMOX_FLAG_C 0
`define EMOX_FLAG_AC 1
`define EMOX_FLAG_Z 2
`define EMOX_FLAG_OV 3
`define EMOX_FLAG_SC 4
`define EMOX_FLAG_CZ 5

// ==========================================================
// exec status register bit positions
`define EMOX_EXEC_BUSY 0
`define EMOX_EXEC_SKIP 1

// ==========================================================
// reset values
`define EMOX_RST_ACC 8'h00
`define EMOX_RST_FLAGS 6'h00

// ==========================================================
// operation codes presented by the sequencer
`define EMOX_OP_OR_TO_MEM 5'h00
`define EMOX_OP_ROTATE_LEFT_MEM 5'h01
`define EMOX_OP_ROTATE_LEFT_TO_ACC 5'h02
`define EMOX_OP_ROTATE_LEFT_CARRY_MEM 5'h03
`define EMOX_OP_ROTATE_LEFT_CARRY_TO_ACC 5'h04
`define EMOX_OP_ROTATE_RIGHT_MEM 5'h05
`define EMOX_OP_ROTATE_RIGHT_TO_ACC 5'h06
`define EMOX_OP_ROTATE_RIGHT_CARRY_MEM 5'h07
`define EMOX_OP_ROTATE_RIGHT_CARRY_TO_ACC 5'h08
`define EMOX_OP_SUB_BORROW_TO_ACC 5'h09
`define EMOX_OP_SUB_BORROW_TO_MEM 5'h0a
`define EMOX_OP_SUB_TO_ACC 5'h0b
`define EMOX_OP_SUB_TO_MEM 5'h0c
`define EMOX_OP_DECREMENT_SKIP_ZERO 5'h0d
`define EMOX_OP_DECREMENT_SKIP_ZERO_ACC 5'h0e
`define EMOX_OP_INCREMENT_SKIP_ZERO 5'h0f
`define EMOX_OP_INCREMENT_SKIP_ZERO_ACC 5'h10
`define EMOX_OP_SET_BYTE 5'h11
`define EMOX_OP_SET_BIT 5'h12
`define EMOX_OP_SKIP_IF_NONZERO_BIT 5'h13
`define EMOX_OP_SKIP_IF_NONZERO 5'h14
`define EMOX_OP_NIBBLE_EXCHANGE_MEM 5'h15
`define EMOX_OP_NIBBLE_EXCHANGE_TO_ACC 5'h16
`define EMOX_OP_SKIP_IF_ZERO 5'h17

`endif

// file: hdl/emox_subtr.v
// ==========================================================
// 8-bit subtractor with borrow in and the arithmetic flags
module emox_subtr (
    // operands
    input wire [7:0] minuend,
    input wire [7:0] subtrahend,
    input wire borrow_in,
    // result and flags
    output wire [7:0] diff,
    output wire carry_out,
    output wire aux_out,
    output wire ovf_out,
    output wire sign_out
);
    wire [8:0] full_diff;
    wire [4:0] low_diff;

    // nine-bit difference, top bit is the borrow out
    assign full_diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
    assign diff = full_diff[7:0];
    // carry is set when no borrow, cleared when negative
    assign carry_out = ~full_diff[8];
    assign aux_out = ~low_diff[4];
    // signed overflow: operands differ in sign and result sign flips
    assign ovf_out = (minuend[7] ^ subtrahend[7]) & (full_diff[7] ^ minuend[7]);
    // true sign of the signed result
    assign sign_out = full_diff[7] ^ ovf_out;
endmodule

// file: hdl/emox_exec.v
// Decided for this implementation: the register offsets and strobed register access.
`include "emox_regs.vh"

module emox_exec #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // instruction issue from the sequencer
    input wire issue_valid,
    input wire [4:0] issue_op,
    input wire [2:0] issue_bit,
    input wire [ADDR_W-1:0] issue_addr,
    output wire issue_ready,
    // completion towards the sequencer
    output wire done,
    output wire skip_taken,
    output wire dummy_cycle,
    // data memory port
    output wire [ADDR_W-1:0] mem_addr,
    output wire mem_rd,
    input wire [7:0] mem_rdata,
    output wire mem_wr,
    output wire [7:0] mem_wdata,
    // software register port
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // core state
    output wire [7:0] accumulator_reg,
    output wire [5:0] flags
);

    // ==========================================================
    // states
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_EXEC = 2'h2;
    localparam ST_DUMMY = 2'h3;

    // ==========================================================
    // helpers
    function [7:0] rot_left;
        input [7:0] val;
        input in_bit;
        begin
            rot_left = {val[6:0], in_bit};
        end
    endfunction

    function [7:0] rot_right;
        input [7:0] val;
        input in_bit;
        begin
            rot_right = {in_bit, val[7:1]};
        end
    endfunction

    function [7:0] nibble_swap;
        input [7:0] val;
        begin
            nibble_swap = {val[3:0], val[7:4]};
        end
    endfunction

    // ==========================================================
    // state
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [4:0] op_ff;
    reg [2:0] bit_ff;
    reg [ADDR_W-1:0] addr_ff;
    reg [7:0] acc_ff;
    reg [5:0] flags_ff;
    reg mem_rd_ff;
    reg mem_wr_ff;
    reg [7:0] mem_wdata_ff;
    reg done_ff;
    reg skip_ff;
    reg dummy_ff;
    reg last_skip_ff;
    reg [7:0] rdata_ff;

    // ==========================================================
    // execute datapath
    reg [7:0] nxt_result;
    reg nxt_to_mem;
    reg nxt_to_acc;
    reg [5:0] nxt_flags;
    reg nxt_skip;
    reg sub_borrow;
    reg [7:0] bit_mask;

    wire flag_c;
    wire [7:0] sub_diff;
    wire sub_carry;
    wire sub_aux;
    wire sub_ovf;
    wire sub_sign;
    wire sub_zero;
    wire [7:0] dec_val;
    wire [7:0] inc_val;

    assign flag_c = flags_ff[`EMOX_FLAG_C];
    assign dec_val = mem_rdata - 8'h01;
    assign inc_val = mem_rdata + 8'h01;
    assign sub_zero = (sub_diff == 8'h00);

    // shared subtractor for both subtract families
    emox_subtr u_subtr (
        .minuend(acc_ff),
        .subtrahend(mem_rdata),
        .borrow_in(sub_borrow),
        .diff(sub_diff),
        .carry_out(sub_carry),
        .aux_out(sub_aux),
        .ovf_out(sub_ovf),
        .sign_out(sub_sign)
    );

    // operation decode and result selection
    always @* begin
        nxt_result = mem_rdata;
        nxt_to_mem = 1'b0;
        nxt_to_acc = 1'b0;
        nxt_flags = flags_ff;
        nxt_skip = 1'b0;
        sub_borrow = 1'b0;
        bit_mask = 8'h01 << bit_ff;
        case (op_ff)
            `EMOX_OP_OR_TO_MEM: begin
                nxt_result = acc_ff | mem_rdata;
                nxt_to_mem = 1'b1;
                nxt_flags[`EMOX_FLAG_Z] = ((acc_ff | mem_rdata) == 8'h00);
            end
            `EMOX_OP_ROTATE_LEFT_MEM: begin
                nxt_result = rot_left(mem_rdata, mem_rdata[7]);
                nxt_to_mem = 1'b1;
            end
            `EMOX_OP_ROTATE_LEFT_TO_ACC: begin
                nxt_result = rot_left(mem_rdata, mem_rdata[7]);
                nxt_to_acc = 1'b1;
            end
            `EMOX_OP_ROTATE_LEFT_CARRY_MEM: begin
                nxt_result = rot_left(mem_rdata, flag_c);
                nxt_to_mem = 1'b1;
                nxt_flags[`EMOX_FLAG_C] = mem_rdata[7];
            end
            `EMOX_OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                nxt_result = rot_left(mem_rdata, flag_c);
                nxt_to_acc = 1'b1;
                nxt_flags[`EMOX_FLAG_C] = mem_rdata[7];
            end
            `EMOX_OP_ROTATE_RIGHT_MEM: begin
                nxt_result = rot_right(mem_rdata, mem_rdata[0]);
                nxt_to_mem = 1'b1;
            end
            `EMOX_OP_ROTATE_RIGHT_TO_ACC: begin
                nxt_result = rot_right(mem_rdata, mem_rdata[0]);
                nxt_to_acc = 1'b1;
            end
            `EMOX_OP_ROTATE_RIGHT_CARRY_MEM: begin
                nxt_result = rot_right(mem_rdata, flag_c);
                nxt_to_mem = 1'b1;
                nxt_flags[`EMOX_FLAG_C] = mem_rdata[0];
            end
            `EMOX_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                nxt_result = rot_right(mem_rdata, flag_c);
                nxt_to_acc = 1'b1;
                nxt_flags[`EMOX_FLAG_C] = mem_rdata[0];
            end
            `EMOX_OP_SUB_BORROW_TO_ACC, `EMOX_OP_SUB_BORROW_TO_MEM: begin
                sub_borrow = ~flag_c;
                nxt_result = sub_diff;
                nxt_to_acc = (op_ff == `EMOX_OP_SUB_BORROW_TO_ACC);
                nxt_to_mem = (op_ff == `EMOX_OP_SUB_BORROW_TO_MEM);
                nxt_flags[`EMOX_FLAG_C] = sub_carry;
                nxt_flags[`EMOX_FLAG_AC] = sub_aux;
                nxt_flags[`EMOX_FLAG_Z] = sub_zero;
                nxt_flags[`EMOX_FLAG_OV] = sub_ovf;
                nxt_flags[`EMOX_FLAG_SC] = sub_sign;
                // chained zero keeps a multi-byte zero result across bytes
                nxt_flags[`EMOX_FLAG_CZ] = sub_zero & flags_ff[`EMOX_FLAG_CZ];
            end
            `EMOX_OP_SUB_TO_ACC, `EMOX_OP_SUB_TO_MEM: begin
                sub_borrow = 1'b0;
                nxt_result = sub_diff;
                nxt_to_acc = (op_ff == `EMOX_OP_SUB_TO_ACC);
                nxt_to_mem = (op_ff == `EMOX_OP_SUB_TO_MEM);
                nxt_flags[`EMOX_FLAG_C] = sub_carry;
                nxt_flags[`EMOX_FLAG_AC] = sub_aux;
                nxt_flags[`EMOX_FLAG_Z] = sub_zero;
                nxt_flags[`EMOX_FLAG_OV] = sub_ovf;
                nxt_flags[`EMOX_FLAG_SC] = sub_sign;
                nxt_flags[`EMOX_FLAG_CZ] = sub_zero;
            end
            `EMOX_OP_DECREMENT_SKIP_ZERO: begin
                nxt_result = dec_val;
                nxt_to_mem = 1'b1;
                nxt_skip = (dec_val == 8'h00);
            end
            `EMOX_OP_DECREMENT_SKIP_ZERO_ACC: begin
                nxt_result = dec_val;
                nxt_to_acc = 1'b1;
                nxt_skip = (dec_val == 8'h00);
            end
            `EMOX_OP_INCREMENT_SKIP_ZERO: begin
                nxt_result = inc_val;
                nxt_to_mem = 1'b1;
                nxt_skip = (inc_val == 8'h00);
            end
            `EMOX_OP_INCREMENT_SKIP_ZERO_ACC: begin
                nxt_result = inc_val;
                nxt_to_acc = 1'b1;
                nxt_skip = (inc_val == 8'h00);
            end
            `EMOX_OP_SET_BYTE: begin
                nxt_result = 8'hff;
                nxt_to_mem = 1'b1;
            end
            `EMOX_OP_SET_BIT: begin
                nxt_result = mem_rdata | bit_mask;
                nxt_to_mem = 1'b1;
            end
            `EMOX_OP_SKIP_IF_NONZERO_BIT: begin
                nxt_skip = ((mem_rdata & bit_mask) != 8'h00);
            end
            `EMOX_OP_SKIP_IF_NONZERO: begin
                nxt_to_mem = 1'b1;
                nxt_skip = (mem_rdata != 8'h00);
            end
            `EMOX_OP_NIBBLE_EXCHANGE_MEM: begin
                nxt_result = nibble_swap(mem_rdata);
                nxt_to_mem = 1'b1;
            end
            `EMOX_OP_NIBBLE_EXCHANGE_TO_ACC: begin
                nxt_result = nibble_swap(mem_rdata);
                nxt_to_acc = 1'b1;
            end
            `EMOX_OP_SKIP_IF_ZERO: begin
                nxt_to_mem = 1'b1;
                nxt_skip = (mem_rdata == 8'h00);
            end
            default: begin
                nxt_result = mem_rdata;
            end
        endcase
    end

    // ==========================================================
    // sequencing
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (issue_valid) begin
                    nxt_state = ST_READ;
                end
            end
            ST_READ: begin
                nxt_state = ST_EXEC;
            end
            ST_EXEC: begin
                // only a taken skip spends the extra dummy cycle
                nxt_state = nxt_skip ? ST_DUMMY : ST_IDLE;
            end
            ST_DUMMY: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state register and captured instruction
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            op_ff <= 5'h00;
            bit_ff <= 3'h0;
            addr_ff <= {ADDR_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && issue_valid) begin
                op_ff <= issue_op;
                bit_ff <= issue_bit;
                addr_ff <= issue_addr;
            end
        end
    end

    // memory strobes, completion and skip signalling
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_wdata_ff <= 8'h00;
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
            dummy_ff <= 1'b0;
            last_skip_ff <= 1'b0;
        end else begin
            mem_rd_ff <= (state_ff == ST_IDLE) && issue_valid;
            mem_wr_ff <= (state_ff == ST_EXEC) && nxt_to_mem;
            if (state_ff == ST_EXEC) begin
                mem_wdata_ff <= nxt_result;
                last_skip_ff <= nxt_skip;
            end
            dummy_ff <= (state_ff == ST_EXEC) && nxt_skip;
            done_ff <= ((state_ff == ST_EXEC) && !nxt_skip) || (state_ff == ST_DUMMY);
            skip_ff <= (state_ff == ST_DUMMY);
        end
    end

    // ==========================================================
    // accumulator and flags, execution wins over a software write
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_ff <= `EMOX_RST_ACC;
            flags_ff <= `EMOX_RST_FLAGS;
        end else begin
            if (state_ff == ST_EXEC && nxt_to_acc) begin
                acc_ff <= nxt_result;
            end else if (reg_wr && reg_addr == `EMOX_REG_ACC) begin
                acc_ff <= reg_wdata;
            end
            if (state_ff == ST_EXEC) begin
                flags_ff <= nxt_flags;
            end else if (reg_wr && reg_addr == `EMOX_REG_FLAGS) begin
                flags_ff <= reg_wdata[5:0];
            end
        end
    end

    // register read data, valid only in the cycle after the strobe
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `EMOX_REG_ACC: rdata_ff <= acc_ff;
                `EMOX_REG_FLAGS: rdata_ff <= {2'b00, flags_ff};
                `EMOX_REG_EXEC: rdata_ff <= {6'h00, last_skip_ff, (state_ff != ST_IDLE)};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ==========================================================
    // outputs
    assign issue_ready = (state_ff == ST_IDLE);
    assign done = done_ff;
    assign skip_taken = skip_ff;
    assign dummy_cycle = dummy_ff;
    assign mem_addr = addr_ff;
    assign mem_rd = mem_rd_ff;
    assign mem_wr = mem_wr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign reg_rdata = rdata_ff;
    assign accumulator_reg = acc_ff;
    assign flags = flags_ff;

endmodule

// file: tb/emox_exec_checker.sv
`include "emox_regs.vh"

// ==========================================================
// port checker for the extended memory operation unit
module emox_exec_checker #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // instruction issue and completion
    input wire issue_valid,
    input wire [4:0] issue_op,
    input wire issue_ready,
    input wire done,
    input wire skip_taken,
    input wire dummy_cycle,
    // data memory port
    input wire mem_rd,
    input wire [7:0] mem_rdata,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    // core state
    input wire [5:0] flags
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [4:0] op_ff;
    reg rd_ff;
    reg ex_ff;
    reg [7:0] dat_ff;

    // track the op in flight and the byte it read, ex_ff marks the cycle after its execute state
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            op_ff <= 5'h00;
            rd_ff <= 1'b0;
            ex_ff <= 1'b0;
            dat_ff <= 8'h00;
        end else begin
            if (issue_valid && issue_ready) begin
                op_ff <= issue_op;
            end
            rd_ff <= mem_rd;
            ex_ff <= rd_ff;
            if (rd_ff) begin
                dat_ff <= mem_rdata;
            end
        end
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // timing of an instruction
    property p_issue_read;
        issue_valid && issue_ready |=> mem_rd && !issue_ready;
    endproperty
    a_issue_read: assert property (p_issue_read) else $error("no read after issue");
    property p_complete;
        issue_valid && issue_ready |-> ##3 (done ^ dummy_cycle);
    endproperty
    a_complete: assert property (p_complete) else $error("late completion");
    property p_skip_len;
        dummy_cycle |=> done && skip_taken;
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("dummy not followed by skip");
    property p_no_dummy;
        done && !skip_taken |-> !$past(dummy_cycle);
    endproperty
    a_no_dummy: assert property (p_no_dummy) else $error("dummy without skip");
    property p_wr_slot;
        mem_wr |-> !mem_rd && (done || dummy_cycle);
    endproperty
    a_wr_slot: assert property (p_wr_slot) else $error("write out of slot");

    // ==========================================================
    // results written back
    property p_rl_mem;
        ex_ff && op_ff == `EMOX_OP_ROTATE_LEFT_MEM |->
            mem_wr && mem_wdata == {dat_ff[6:0], dat_ff[7]} && $stable(flags);
    endproperty
    a_rl_mem: assert property (p_rl_mem) else $error("bad left rotate");
    property p_rr_mem;
        ex_ff && op_ff == `EMOX_OP_ROTATE_RIGHT_MEM |->
            mem_wr && mem_wdata == {dat_ff[0], dat_ff[7:1]};
    endproperty
    a_rr_mem: assert property (p_rr_mem) else $error("bad right rotate");
    property p_set_byte;
        ex_ff && op_ff == `EMOX_OP_SET_BYTE |-> mem_wr && mem_wdata == 8'hff;
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("bad byte set");
    property p_swap;
        ex_ff && op_ff == `EMOX_OP_NIBBLE_EXCHANGE_MEM |->
            mem_wr && mem_wdata == {dat_ff[3:0], dat_ff[7:4]};
    endproperty
    a_swap: assert property (p_swap) else $error("bad nibble swap");
    property p_acc_no_wr;
        ex_ff && (op_ff == `EMOX_OP_ROTATE_LEFT_TO_ACC ||
            op_ff == `EMOX_OP_NIBBLE_EXCHANGE_TO_ACC) |-> !mem_wr;
    endproperty
    a_acc_no_wr: assert property (p_acc_no_wr) else $error("memory written");

    // main scenarios reached
    c_skip: cover property (dummy_cycle ##1 done);
    c_write: cover property (mem_wr && done);
    c_plain: cover property (done && !skip_taken);
endmodule

bind emox_exec emox_exec_checker #(.ADDR_W(ADDR_W)) emox_exec_checker_inst (
    .clock(clock), .rst(rst), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_ready(issue_ready), .done(done), .skip_taken(skip_taken),
    .dummy_cycle(dummy_cycle), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .flags(flags)
);

// file: tb/emox_mem_model.sv
// ==========================================================
// data memory answering one cycle after each read
module emox_mem_model (
    // clock
    input wire clock,
    // memory port
    input wire [7:0] mem_addr,
    input wire mem_rd,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];

    // read data stand one cycle only, otherwise the bus toggles
    initial mem_rdata = 8'h00;
    always @(posedge clock) begin
        if (mem_rd) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

// file: tb/emox_exec_tb_top.sv
// ==========================================================
// self-checking bench: every opcode over four operand sets
module emox_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, issue_valid, reg_wr, reg_rd, es, sk;
    logic [4:0] issue_op;
    logic [2:0] issue_bit, b;
    logic [7:0] issue_addr, reg_wdata, v, m, a, em, ea, ad;
    logic [1:0] reg_addr;
    logic [5:0] f, ef;
    wire issue_ready, done, skip_taken, dummy_cycle, mem_rd, mem_wr;
    wire [7:0] mem_addr, mem_rdata, mem_wdata, reg_rdata, accumulator_reg;
    wire [5:0] flags;
    int n_mismatch, check_count, n;
    logic [7:0] mt [4] = '{8'h00, 8'h01, 8'hff, 8'h80};
    logic [7:0] at [4] = '{8'h00, 8'h80, 8'h7f, 8'h01};
    logic [5:0] ft [4] = '{6'h3f, 6'h00, 6'h01, 6'h20};

    emox_exec #(.ADDR_W(8)) emox_exec_inst (.clock(clock), .rst(rst),
        .issue_valid(issue_valid), .issue_op(issue_op), .issue_bit(issue_bit),
        .issue_addr(issue_addr), .issue_ready(issue_ready), .done(done),
        .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .accumulator_reg(accumulator_reg), .flags(flags));
    emox_mem_model emox_mem_model_inst (.clock(clock), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================================
    // reference results: new byte, accumulator, flags and skip
    function automatic void calc(input logic [4:0] op, input logic [2:0] b,
        input logic [7:0] m, a, input logic [5:0] f,
        output logic [7:0] nm, na, output logic [5:0] nf, output logic sk);
        logic [8:0] d;
        logic [4:0] lo;
        logic bin, ov, z;
        nm = m;
        na = a;
        nf = f;
        sk = 1'b0;
        bin = (op == 5'h09 || op == 5'h0a) ? ~f[0] : 1'b0;
        d = {1'b0, a} - {1'b0, m} - bin;
        lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - bin;
        ov = (a[7] ^ m[7]) & (d[7] ^ a[7]);
        z = (d[7:0] == 8'h00);
        case (op)
            5'h00: nm = a | m;
            5'h01: nm = {m[6:0], m[7]};
            5'h02: na = {m[6:0], m[7]};
            5'h03: nm = {m[6:0], f[0]};
            5'h04: na = {m[6:0], f[0]};
            5'h05: nm = {m[0], m[7:1]};
            5'h06: na = {m[0], m[7:1]};
            5'h07: nm = {f[0], m[7:1]};
            5'h08: na = {f[0], m[7:1]};
            5'h09, 5'h0b: na = d[7:0];
            5'h0a, 5'h0c: nm = d[7:0];
            5'h0d: nm = m - 8'h01;
            5'h0e: na = m - 8'h01;
            5'h0f: nm = m + 8'h01;
            5'h10: na = m + 8'h01;
            5'h11: nm = 8'hff;
            5'h12: nm[b] = 1'b1;
            5'h13: sk = m[b];
            5'h14: sk = (m != 8'h00);
            5'h15: nm = {m[3:0], m[7:4]};
            5'h16: na = {m[3:0], m[7:4]};
            5'h17: sk = (m == 8'h00);
            default: ;
        endcase
        if (op == 5'h00) nf[2] = (nm == 8'h00);
        if (op == 5'h03 || op == 5'h04) nf[0] = m[7];
        if (op == 5'h07 || op == 5'h08) nf[0] = m[0];
        if (op >= 5'h09 && op <= 5'h0c) nf = {(bin | op == 5'h09 | op == 5'h0a) ?
            z & f[5] : z, d[7] ^ ov, ov, z, ~lo[4], ~d[8]};
        if (op == 5'h0d || op == 5'h0f) sk = (nm == 8'h00);
        if (op == 5'h0e || op == 5'h10) sk = (na == 8'h00);
    endfunction

    // ==========================================================
    // comparison, verdict and port tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [1:0] ra, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= ra;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] ra, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= ra;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // issue one op and count cycles after it was taken until done
    task automatic run(input logic [4:0] op, input logic [2:0] ib, input logic [7:0] ia);
        @(posedge clock);
        issue_valid <= 1'b1;
        issue_op <= op;
        issue_bit <= ib;
        issue_addr <= ia;
        @(posedge clock);
        issue_valid <= 1'b0;
        // n numbers the cycles after the accepting edge, the first being cycle 1
        for (n = 1; n < 9; n++) begin
            @(posedge clock);
            #1;
            if (done === 1'b1) break;
        end
        sk = skip_taken;
        if (n == 9) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {issue_valid, issue_op, issue_bit, issue_addr} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        n_mismatch = 0;
        check_count = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(2'h1, v);
        check(v, 8'h00);
        wr(2'h3, 8'h5a);
        rd(2'h3, v);
        check(v, 8'h00);
        for (int op = 0; op < 25; op++) begin
            for (int k = 0; k < 4; k++) begin
                m = mt[k];
                a = at[k];
                f = ft[k];
                b = 3'(2 * k + 1);
                ad = {1'b0, op[4:0], k[1:0]};
                emox_mem_model_inst.mem[ad] = m;
                wr(2'h0, a);
                wr(2'h1, {2'h0, f});
                calc(op[4:0], b, m, a, f, em, ea, ef, es);
                run(op[4:0], b, ad);
                check({7'h0, sk}, {7'h0, es});
                check(n[7:0], es ? 8'h03 : 8'h02);
                check(accumulator_reg, ea);
                check({2'h0, flags}, {2'h0, ef});
                rd(2'h0, v);
                check(v, ea);
                rd(2'h1, v);
                check(v, {2'h0, ef});
                rd(2'h2, v);
                check(v, {6'h0, es, 1'b0});
                check(emox_mem_model_inst.mem[ad], em);
            end
        end
        finish_test();
    end
endmodule
